// ==== src/tsi_map.svh ====
// Constants of the two-wire slave: addresses, commands, timing.
// Assumes inclusion by tsi_pkg and the slave module only.
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

// ------------------------------------------------------------
// Bus addresses and codes
// ------------------------------------------------------------
`define TSI_ADDR_BASE 7'h48
`define TSI_ALERT_RESP 8'h19
`define TSI_GCALL_ADDR 7'h00
`define TSI_GC_LATCH 8'h04
`define TSI_GC_RESET 8'h06
`define TSI_HS_PREFIX 5'h01
`define TSI_PTR_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TSI_CLK_MHZ 250
`define TSI_TIMEOUT_MS 30
`define TSI_TIMEOUT_CYCLES (`TSI_TIMEOUT_MS * 1000 * `TSI_CLK_MHZ)
`define TSI_STUCK_W 24

`endif

// ==== src/tsi_pkg.sv ====
// Types of the temperature-sensor two-wire slave.
// Assumes tsi_map.svh on the include path.
package tsi_pkg;
`include "tsi_map.svh"

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} tsi_state_t;
  typedef enum logic [2:0] {K_NONE, K_WRITE, K_READ, K_ALERT, K_GCALL} tsi_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic lsb;
    logic strobe;
  } tsi_wr_t;

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] strapSync;
    logic sclPrev;
    logic sdaPrev;
    logic strapPrev;
    logic s0;
    logic s1;
    logic s2;
    logic firstFall;
    tsi_state_t st;
    tsi_kind_t kind;
    logic [2:0] bitCnt;
    logic [1:0] byteNo;
    logic [7:0] shiftReg;
    logic [7:0] txByte;
    logic txLsb;
    logic byteReady;
    logic ackPend;
    logic busy;
    logic [`TSI_STUCK_W-1:0] stuckCnt;
    logic sdaOe;
    logic sdaOut;
    logic [7:0] ptr;
    logic [6:0] devAddr;
    tsi_wr_t wr;
    logic genReset;
    logic alertClear;
    logic hsMode;
  } tsi_state_s_t;
endpackage

// ==== src/tsi_two_wire_slave.sv ====
// Two-wire / SMBus slave of a temperature sensor, oversampling the bus on clk.
// Assumes the register bank and alert logic sit outside on the same clock;
// SCL, SDA and the strap pin arrive asynchronously and are synchronised here.
//
// What this block does
// - Decode 7-bit address plus direction bit
// - Strap connection selects one of four addresses
// - Sample strap at start of every transfer
// - Acknowledge matching address, write bytes and general-call codes 04/06
// - First write byte loads the pointer
// - Reads use last written pointer, kept
// - Pointer-only write is accepted
// - Data bytes written and acknowledged; start/stop end
// - Transmit MSB byte then LSB byte
// - Master NACK or start/stop ends read
// - SDA change with SCL high is start/stop
// - Answer alert response only when alert active
// - Returned LSB tells over or under limit
// - Arbitrate; winner clears alert, loser keeps it
// - Acknowledge general call with write bit
// - General call 04 re-latches strap only
// - General call 06 restores power-up values
// - Hs master code: no ack, Hs filters on
// - Hs mode held until stop
// - Bus low 30 ms resets interface
// - Every byte sent MSB first
// - Alert response clears only the alert output
// - General-call reset also clears alert
`timescale 1ns/1ps
`include "tsi_map.svh"

module tsi_two_wire_slave #(
  parameter int unsigned TIMEOUT_CYCLES = `TSI_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic strapPin,
  input wire logic alertActive,
  input wire logic overLimitFlag,
  input wire logic [15:0] regRdData,
  output logic [7:0] ptrValue,
  output tsi_pkg::tsi_wr_t wrPort,
  output logic genReset,
  output logic alertClear,
  output logic hsMode,
  output logic [6:0] devAddr
);
  import tsi_pkg::*;

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  generate
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << `TSI_STUCK_W)) begin : g_bad_timeout
      $error("TIMEOUT_CYCLES out of range");
    end
  endgenerate

  localparam logic [`TSI_STUCK_W-1:0] TimeoutLim = `TSI_STUCK_W'(TIMEOUT_CYCLES);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  // Strap level before start, after start, at first SCL low
  function automatic logic [6:0] strapAddr(input logic b0, input logic b1, input logic b2);
    logic [1:0] code;
    if (!b0) begin
      code = 2'h0;
    end else if (!b1) begin
      code = 2'h2;
    end else if (!b2) begin
      code = 2'h3;
    end else begin
      code = 2'h1;
    end
    return `TSI_ADDR_BASE | {5'h00, code};
  endfunction

  function automatic logic [7:0] txLoad(input tsi_kind_t k, input logic lsb, input logic [6:0] a,
                                        input logic ovr, input logic [15:0] rd);
    if (k == K_ALERT) begin
      return {a, ovr};
    end else if (lsb) begin
      return rd[7:0];
    end else begin
      return rd[15:8];
    end
  endfunction

  tsi_state_s_t q;
  tsi_state_s_t n;
  logic sclS;
  logic sdaS;
  logic rise;
  logic fall;
  logic startC;
  logic stopC;
  logic timeoutHit;
  logic byteDone;
  logic [7:0] rxByte;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.wr.strobe = 1'b0;
    n.genReset = 1'b0;
    n.alertClear = 1'b0;
    n.sclSync = {q.sclSync[0], sclPin};
    n.sdaSync = {q.sdaSync[0], sdaIn};
    n.strapSync = {q.strapSync[0], strapPin};
    n.sclPrev = q.sclSync[1];
    n.sdaPrev = q.sdaSync[1];
    n.strapPrev = q.strapSync[1];
    sclS = q.sclSync[1];
    sdaS = q.sdaSync[1];
    rise = sclS & ~q.sclPrev;
    fall = ~sclS & q.sclPrev;
    startC = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
    stopC = sclS & q.sclPrev & ~q.sdaPrev & sdaS;
    rxByte = {q.shiftReg[6:0], sdaS};
    byteDone = (q.st == ST_RX) && rise && (q.bitCnt == 3'h7);
    timeoutHit = q.busy && (q.stuckCnt == TimeoutLim);
    if (q.busy && (!sclS || !sdaS)) begin
      n.stuckCnt = q.stuckCnt + `TSI_STUCK_W'(1);
    end else begin
      n.stuckCnt = '0;
    end

    if (startC) begin
      n.st = ST_RX;
      n.busy = 1'b1;
      n.bitCnt = 3'h0;
      n.byteNo = 2'h0;
      n.sdaOe = 1'b0;
      n.kind = K_NONE;
      n.byteReady = 1'b0;
      n.ackPend = 1'b0;
      n.s0 = q.strapPrev;
      n.s1 = q.strapSync[1];
      n.firstFall = 1'b1;
    end else if (stopC) begin
      n.st = ST_IDLE;
      n.busy = 1'b0;
      n.sdaOe = 1'b0;
      n.hsMode = 1'b0;
    end else if (timeoutHit) begin
      n.st = ST_IDLE;
      n.busy = 1'b0;
      n.sdaOe = 1'b0;
      n.stuckCnt = '0;
    end else begin
      if (fall && q.firstFall) begin
        n.firstFall = 1'b0;
        n.s2 = q.strapSync[1];
        n.devAddr = strapAddr(q.s0, q.s1, q.strapSync[1]);
      end
      case (q.st)
        ST_IDLE: begin
          n.sdaOe = 1'b0;
        end
        ST_RX: begin
          if (rise) begin
            n.shiftReg = rxByte;
            n.bitCnt = q.bitCnt + 3'h1;
          end
          if (byteDone) begin
            n.byteReady = 1'b1;
            n.ackPend = 1'b0;
            if (q.byteNo == 2'h0) begin
              if (rxByte[7:1] == q.devAddr) begin
                n.ackPend = 1'b1;
                n.kind = rxByte[0] ? K_READ : K_WRITE;
              end else if (rxByte == `TSI_ALERT_RESP && alertActive) begin
                n.ackPend = 1'b1;
                n.kind = K_ALERT;
              end else if (rxByte == {`TSI_GCALL_ADDR, 1'b0}) begin
                n.ackPend = 1'b1;
                n.kind = K_GCALL;
              end else if (rxByte[7:3] == `TSI_HS_PREFIX) begin
                n.hsMode = 1'b1;
              end
            end else if (q.kind == K_WRITE) begin
              n.ackPend = 1'b1;
              if (q.byteNo == 2'h1) begin
                n.ptr = rxByte;
              end else begin
                n.wr.data = rxByte;
                n.wr.lsb = q.byteNo[0];
                n.wr.strobe = 1'b1;
              end
            end else if (q.kind == K_GCALL && q.byteNo == 2'h1) begin
              if (rxByte == `TSI_GC_LATCH) begin
                n.ackPend = 1'b1;
                n.devAddr = strapAddr(q.s0, q.s1, q.s2);
              end else if (rxByte == `TSI_GC_RESET) begin
                n.ackPend = 1'b1;
                n.ptr = `TSI_PTR_RESET;
                n.genReset = 1'b1;
                n.alertClear = 1'b1;
              end
            end
          end else if (fall && q.byteReady) begin
            n.byteReady = 1'b0;
            if (q.ackPend) begin
              n.st = ST_ACK;
              n.sdaOe = 1'b1;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            n.sdaOe = 1'b0;
            n.bitCnt = 3'h0;
            n.byteNo = (q.byteNo == 2'h3) ? 2'h2 : q.byteNo + 2'h1;
            if (q.kind == K_READ || q.kind == K_ALERT) begin
              n.st = ST_TX;
              n.txLsb = 1'b0;
              n.txByte = txLoad(q.kind, 1'b0, q.devAddr, overLimitFlag, regRdData);
              n.sdaOe = ~n.txByte[7];
            end else begin
              n.st = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            n.bitCnt = q.bitCnt + 3'h1;
            if (q.kind == K_ALERT && !q.sdaOe && !sdaS) begin
              n.st = ST_IDLE;
            end
          end else if (fall) begin
            if (q.bitCnt == 3'h0) begin
              n.sdaOe = 1'b0;
              n.st = ST_MACK;
              n.ackPend = 1'b0;
            end else begin
              n.txByte = {q.txByte[6:0], 1'b0};
              n.sdaOe = ~q.txByte[6];
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            if (q.kind == K_ALERT) begin
              n.alertClear = 1'b1;
              n.st = ST_IDLE;
            end else if (sdaS) begin
              n.st = ST_IDLE;
            end else begin
              n.ackPend = 1'b1;
            end
          end else if (fall && q.ackPend) begin
            n.ackPend = 1'b0;
            n.st = ST_TX;
            n.bitCnt = 3'h0;
            n.txLsb = ~q.txLsb;
            n.txByte = txLoad(q.kind, ~q.txLsb, q.devAddr, overLimitFlag, regRdData);
            n.sdaOe = ~n.txByte[7];
          end
        end
        default: begin
          n.st = ST_IDLE;
          n.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.sclSync <= 2'h3;
      q.sdaSync <= 2'h3;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.st <= ST_IDLE;
      q.kind <= K_NONE;
      q.ptr <= `TSI_PTR_RESET;
      q.devAddr <= `TSI_ADDR_BASE;
    end else if (ce) begin
      q <= n;
    end
  end

  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign ptrValue = q.ptr;
  assign wrPort = q.wr;
  assign genReset = q.genReset;
  assign alertClear = q.alertClear;
  assign hsMode = q.hsMode;
  assign devAddr = q.devAddr;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_ACK_DRIVES_LOW: assert property (q.st == ST_ACK |-> q.sdaOe)
    else $error("ack slot not driven low");
  AST_OWN_ADDR_ACK: assert property (ce && byteDone && q.byteNo == 2'h0 && rxByte[7:1] == q.devAddr
    |=> q.ackPend && q.kind == ($past(rxByte[0]) ? K_READ : K_WRITE))
    else $error("own address not accepted");
  AST_FOREIGN_NO_ACK: assert property (ce && byteDone && q.byteNo == 2'h0 && rxByte[7:1] != q.devAddr
    && rxByte != `TSI_ALERT_RESP && rxByte != 8'h00 |=> !q.ackPend)
    else $error("foreign address acknowledged");
  AST_ALERT_ONLY_ACTIVE: assert property (ce && byteDone && q.byteNo == 2'h0 && !alertActive
    && rxByte == `TSI_ALERT_RESP |=> q.kind != K_ALERT)
    else $error("alert response while alert inactive");
  AST_PTR_KEPT: assert property (ce && q.kind != K_WRITE && q.kind != K_GCALL |=> $stable(q.ptr))
    else $error("pointer changed outside a write");
  AST_HS_ENTRY: assert property (ce && byteDone && q.byteNo == 2'h0 && rxByte[7:3] == `TSI_HS_PREFIX
    |=> q.hsMode && !q.ackPend)
    else $error("Hs code mishandled");
  AST_HS_EXIT: assert property (ce && stopC |=> !q.hsMode)
    else $error("Hs mode survived stop");
  AST_TIMEOUT: assert property (ce && timeoutHit |=> !q.busy && !q.sdaOe && q.st == ST_IDLE)
    else $error("timeout did not release bus");
  AST_GC_RESET: assert property (q.genReset |-> q.alertClear && q.ptr == `TSI_PTR_RESET)
    else $error("general-call reset incomplete");
  AST_MACK_RELEASED: assert property (q.st == ST_MACK |-> !q.sdaOe)
    else $error("SDA driven in master ack slot");
  AST_START_RESTARTS: assert property (ce && startC |=> q.st == ST_RX && q.bitCnt == 3'h0)
    else $error("start not honoured");

  COV_READ_LSB: cover property (q.st == ST_TX && q.txLsb && q.kind == K_READ);
  COV_ALERT_CLEAR: cover property (q.alertClear && !q.genReset);
  COV_HS_MODE: cover property (!q.hsMode ##1 q.hsMode);
  COV_WRITE_DATA: cover property (q.wr.strobe && q.wr.lsb);

endmodule // tsi_two_wire_slave

// ==== tb/temp_sensor_two_wire_slave_tb_top.sv ====
// Self-checking bench of the two-wire slave with a bus master model.
// Assumes tsi_pkg compiled first; timeout shortened to 2000 cycles.
`timescale 1ns/1ps

module temp_sensor_two_wire_slave_tb_top;
  import tsi_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, alertActive = 1'b0, overLimitFlag = 1'b0;
  logic [15:0] regRdData = 16'h0000;
  logic [1:0] strapSel = 2'h0;
  logic sdaOut, sdaOe, genReset, alertClear, hsMode, sclOut, sdaLow, strapPin, sdaWire;
  logic [7:0] ptrValue, b, p, d0, d1;
  logic [6:0] devAddr;
  logic [15:0] w;
  logic ack, o, s;
  tsi_wr_t wrPort;
  int n_errors = 0, comparisons = 0, nClear = 0, nGen = 0, c0, c1;
  logic [8:0] wrLog[$];
  logic [7:0] gcCmd[3] = '{8'h04, 8'h06, 8'h05};

  always #2 clk = ~clk;
  assign sdaWire = !((sdaOe && !sdaOut) || sdaLow);
  always_comb begin
    case (strapSel)
      2'h0: strapPin = 1'b0;
      2'h1: strapPin = 1'b1;
      2'h2: strapPin = sdaWire;
      default: strapPin = sclOut;
    endcase
  end

  tsi_two_wire_slave #(.TIMEOUT_CYCLES(2000)) dut (.clk(clk), .reset_n(reset_n), .ce(1'b1),
    .sclPin(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapPin(strapPin),
    .alertActive(alertActive), .overLimitFlag(overLimitFlag), .regRdData(regRdData),
    .ptrValue(ptrValue), .wrPort(wrPort), .genReset(genReset), .alertClear(alertClear),
    .hsMode(hsMode), .devAddr(devAddr));
  tsi_bus_master m (.clk(clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaLow(sdaLow));

  always @(posedge clk) begin
    if (wrPort.strobe === 1'b1) wrLog.push_back({wrPort.lsb, wrPort.data});
    if (alertClear === 1'b1) nClear++;
    if (genReset === 1'b1) nGen++;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("Error watchdog expected end seen hang");
    test_done();
  end

  initial begin
    p = $urandom(9012);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ptrValue", 16'h0000, ptrValue);
    chk("devAddr", 16'h0048, devAddr);
    chk("hsMode", 16'h0000, hsMode);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      strapSel <= 2'(k);
      p = 8'($urandom) | 8'h01;
      m.start();
      m.wbyte({7'h48 + 7'(k), 1'b0}, ack);
      chk("addrAck", 16'h0000, ack);
      m.wbyte(p, ack);
      chk("ptrAck", 16'h0000, ack);
      m.stop();
      chk("ptrValue", p, ptrValue);
      chk("devAddr", 7'h48 + 7'(k), devAddr);
    end
    strapSel <= 2'h0;
    $display("test strap done");
    d0 = $urandom;
    d1 = $urandom;
    wrLog.delete();
    m.start();
    m.wbyte(8'h90, ack);
    m.wbyte(p, ack);
    m.wbyte(d0, ack);
    chk("dataAck", 16'h0000, ack);
    m.wbyte(d1, ack);
    m.stop();
    chk("wrCount", 16'h0002, wrLog.size());
    chk("wrFirst", {1'b0, d0}, wrLog[0]);
    chk("wrSecond", {1'b1, d1}, wrLog[1]);
    $display("test write done");
    for (int k = 0; k < 2; k++) begin
      w = $urandom;
      regRdData <= w;
      m.start();
      m.wbyte(8'h91, ack);
      chk("rdAck", 16'h0000, ack);
      m.rbyte(1'b1, b);
      chk("rdMsb", w[15:8], b);
      m.rbyte(1'b0, b);
      chk("rdLsb", w[7:0], b);
      chk("rdRelease", 16'h0000, sdaOe);
      m.stop();
      chk("ptrKept", p, ptrValue);
    end
    $display("test read done");
    foreach (gcCmd[k]) begin
      m.start();
      m.wbyte(8'h00, ack);
      chk("gcAck", 16'h0000, ack);
      c0 = nGen;
      c1 = nClear;
      m.wbyte(gcCmd[k], ack);
      m.stop();
      chk("gcCmdAck", k == 2, ack);
      chk("gcReset", k == 1, nGen - c0);
      chk("gcAlertClr", k == 1, nClear - c1);
      if (k == 1) chk("gcPtr", 16'h0000, ptrValue);
      if (k == 0) chk("gcAddr", 16'h0048, devAddr);
    end
    $display("test general call done");
    foreach (gcCmd[k]) begin
      m.start();
      m.wbyte(k == 0 ? 8'h98 : (k == 1 ? 8'h19 : 8'h01), ack);
      m.stop();
      chk("foreignNack", 16'h0001, ack);
    end
    $display("test refuse done");
    alertActive <= 1'b1;
    o = 1'($urandom);
    overLimitFlag <= o;
    c0 = nClear;
    m.start();
    m.wbyte(8'h19, ack);
    chk("alertAck", 16'h0000, ack);
    m.rbyte(1'b0, b);
    m.stop();
    chk("alertByte", {7'h48, o}, b);
    chk("alertWin", 16'h0001, nClear - c0);
    m.start();
    m.wbyte(8'h19, ack);
    m.wbyte(8'h00, ack);
    m.stop();
    chk("alertLost", 16'h0001, nClear - c0);
    alertActive <= 1'b0;
    $display("test alert done");
    m.start();
    m.wbyte(8'h0a, ack);
    chk("hsNack", 16'h0001, ack);
    chk("hsOn", 16'h0001, hsMode);
    m.start();
    m.wbyte(8'h90, ack);
    chk("hsKept", 16'h0001, hsMode);
    m.stop();
    chk("hsOff", 16'h0000, hsMode);
    $display("test high speed done");
    m.start();
    for (int i = 7; i >= 0; i--) m.bitx(i == 7 || i == 4 || i == 3, s);
    m.start();
    for (int i = 7; i >= 0; i--) m.bitx(i == 7 || i == 4, s);
    repeat (20) @(posedge clk);
    chk("stuckAck", 16'h0001, sdaOe);
    chk("sdaOutLow", 16'h0000, sdaOut);
    repeat (2100) @(posedge clk);
    chk("stuckRelease", 16'h0000, sdaOe);
    m.stop();
    m.start();
    m.wbyte(8'h90, ack);
    m.stop();
    chk("afterStuck", 16'h0000, ack);
    $display("test timeout done");
    test_done();
  end
endmodule // temp_sensor_two_wire_slave_tb_top

// ==== tb/tsi_bus_master.sv ====
// Bus master model driving SCL and pulling SDA for the two-wire slave bench.
// Assumes the bench resolves a pulled-up SDA wire from all pull-downs.
`timescale 1ns/1ps

module tsi_bus_master (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  // ------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------
  // Quarter bit of 5 clk gives an 80 ns SCL period
  task automatic q();
    repeat (5) @(posedge clk);
  endtask

  // Data changes only while SCL is low
  task automatic bitx(input logic b, output logic s);
    q();
    sdaLow <= !b;
    q();
    sclOut <= 1'b1;
    q();
    s = sdaWire;
    q();
    sclOut <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  task automatic start();
    q();
    sdaLow <= 1'b0;
    q();
    sclOut <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    sclOut <= 1'b0;
  endtask

  // Leaves both lines released and still
  task automatic stop();
    q();
    sdaLow <= 1'b1;
    q();
    sclOut <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask

  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, nack);
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(!ack, s);
  endtask
endmodule // tsi_bus_master
